// >>> hw/gcm_global_config.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
//
// Contract
// - Bank bit 0 maps device registers (0) or memory (1) at 0x1 upward.
// - Bank bit is write-only; reads return zero, software tracks it.
// - Bank mapping acts only on the variant with internal memory.
// - Reset bit 7 holds device in reset; other fields return to default.
// - Software reset restores the fixed pin-reset defaults (RST_MCFG1).
// - Bit 5 set takes master clock from input clock one, overriding bit 4.
// - Bit 4 picks ring oscillator (0) or external pin (1).
// - After reset the ring oscillator runs and is selected.
// - Bit 3 set powers down the ring oscillator.
// - Pin mode 00 off, 01 crystal driver, 10 single-ended, 11 unused.
//
module gcm_global_config #(
   parameter bit HAS_INT_MEM = 1'b1
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic mem_bank_sel,
   output logic mem_window_hit,
   output logic dev_reset,
   output logic [1:0] master_clock_src,
   output logic ring_osc_en,
   output logic clock_doubler_enable,
   output logic xtal_drv_en,
   output logic xa_se_en
);
   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic bank_r;
   logic bank_nxt;
   logic [7:0] mcfg_r;
   logic [7:0] mcfg_nxt;
   logic [7:0] rdata_nxt;
   logic swrst;
   logic wr_bank;
   logic wr_mcfg;
   logic bank_eff;
   gcm_pkg::gcm_src_t src_nxt;
   gcm_pkg::gcm_xab_t xab_nxt;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   assign swrst = mcfg_r[gcm_pkg::BIT_SWRST];
   // Bank register stays at 0x0 whatever the bank
   assign wr_bank = reg_wr && hit(reg_addr, gcm_pkg::ADDR_BANK_SEL);
   // Memory bank hides device registers from 0x1 upward
   assign bank_eff = bank_r && HAS_INT_MEM;
   assign wr_mcfg = reg_wr && hit(reg_addr, gcm_pkg::ADDR_MCFG1)
      && !bank_eff;
   // Reset bit set or held: every other field back to default
   assign mcfg_nxt = (swrst || reg_wdata[gcm_pkg::BIT_SWRST]) ?
      ((reg_wdata & gcm_pkg::MASK_SWRST)
       | (gcm_pkg::RST_MCFG1 & ~gcm_pkg::MASK_SWRST)) :
      (reg_wdata & gcm_pkg::MASK_MCFG1);
   // Bank bit forced to default while in software reset
   assign bank_nxt = swrst ? gcm_pkg::RST_BANK_SEL[gcm_pkg::BIT_BANK] :
      (wr_bank ? reg_wdata[gcm_pkg::BIT_BANK] : bank_r);
   // Bank bit never reads back
   assign rdata_nxt = (hit(reg_addr, gcm_pkg::ADDR_MCFG1) && !bank_eff)
      ? mcfg_r : gcm_pkg::RD_UNMAPPED;
   assign src_nxt = mcfg_nxt[gcm_pkg::BIT_SEL_IC1] ? gcm_pkg::GCM_SRC_IC1 :
      (mcfg_nxt[gcm_pkg::BIT_SEL_XA] ? gcm_pkg::GCM_SRC_XA :
       gcm_pkg::GCM_SRC_RING);
   assign xab_nxt = gcm_pkg::gcm_xab_t'(
      mcfg_nxt[gcm_pkg::BIT_XAB_HI:gcm_pkg::BIT_XAB_LO]);

   // ------------------------------------------------------------------
   // Register storage and derived outputs
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         bank_r <= gcm_pkg::RST_BANK_SEL[gcm_pkg::BIT_BANK];
      end else begin
         bank_r <= bank_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mcfg_r <= gcm_pkg::RST_MCFG1;
      end else if (wr_mcfg) begin
         mcfg_r <= mcfg_nxt;
      end else if (swrst) begin
         mcfg_r <= gcm_pkg::RST_MCFG1 | gcm_pkg::MASK_SWRST;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_bank_sel <= 1'b0;
         mem_window_hit <= 1'b0;
         dev_reset <= 1'b0;
         master_clock_src <= gcm_pkg::GCM_SRC_RING;
         ring_osc_en <= 1'b1;
         clock_doubler_enable <= 1'b0;
         xtal_drv_en <= 1'b0;
         xa_se_en <= 1'b0;
      end else begin
         mem_bank_sel <= bank_nxt && HAS_INT_MEM;
         mem_window_hit <= (reg_wr || reg_rd) && bank_eff
            && (reg_addr >= gcm_pkg::ADDR_BANK_LO);
         if (wr_mcfg) begin
            dev_reset <= mcfg_nxt[gcm_pkg::BIT_SWRST];
            master_clock_src <= src_nxt;
            ring_osc_en <= !mcfg_nxt[gcm_pkg::BIT_ROSC_DIS];
            clock_doubler_enable <= mcfg_nxt[gcm_pkg::BIT_DBL];
            xtal_drv_en <= (xab_nxt == gcm_pkg::GCM_XAB_XTAL);
            xa_se_en <= (xab_nxt == gcm_pkg::GCM_XAB_SE);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= gcm_pkg::RD_UNMAPPED;
      end else begin
         reg_rdata <= reg_rd ? rdata_nxt : gcm_pkg::RD_UNMAPPED;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence seq_swrst_write;
      wr_mcfg && mcfg_nxt[gcm_pkg::BIT_SWRST];
   endsequence

   sequence seq_reset_outputs;
      dev_reset && ring_osc_en
      && master_clock_src == gcm_pkg::GCM_SRC_RING
      && !clock_doubler_enable && !xtal_drv_en && !xa_se_en;
   endsequence

   sequence seq_bank_write;
      wr_bank && !swrst;
   endsequence

   sequence seq_swrst_clear;
      swrst && wr_mcfg && !reg_wdata[gcm_pkg::BIT_SWRST];
   endsequence

   // ------------------------------------------------------------------
   // Bank select and read port
   // ------------------------------------------------------------------
   AST_BANK_NO_READ: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      reg_rd && hit(reg_addr, gcm_pkg::ADDR_BANK_SEL)
      |=> reg_rdata == gcm_pkg::RD_UNMAPPED)
      else $error("bank select read back a value");

   AST_NO_MEM_VARIANT: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !HAS_INT_MEM |-> !mem_bank_sel)
      else $error("bank mapped on variant without memory");

   AST_BANK_WRITE: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      seq_bank_write |=> mem_bank_sel ==
      ($past(reg_wdata[gcm_pkg::BIT_BANK]) && HAS_INT_MEM))
      else $error("bank select output does not follow write");

   AST_BANK_HIDES: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      bank_eff && reg_wr && hit(reg_addr, gcm_pkg::ADDR_MCFG1)
      |=> $stable(mcfg_r))
      else $error("device register written while memory mapped");

   AST_BANK_READ_MEM: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      reg_rd && bank_eff |=> reg_rdata == gcm_pkg::RD_UNMAPPED)
      else $error("device register read while memory mapped");

   AST_WINDOW_HIT: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      reg_rd && bank_eff && reg_addr >= gcm_pkg::ADDR_BANK_LO
      |=> mem_window_hit)
      else $error("memory window access not flagged");

   AST_NO_WINDOW_DEV: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !bank_eff |=> !mem_window_hit)
      else $error("memory window flagged with device bank");

   AST_RD_MCFG: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      reg_rd && hit(reg_addr, gcm_pkg::ADDR_MCFG1) && !bank_eff
      |=> reg_rdata == $past(mcfg_r))
      else $error("configuration read data wrong");

   AST_RDATA_IDLE: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !reg_rd |=> reg_rdata == gcm_pkg::RD_UNMAPPED)
      else $error("read data not idle without read");

   // ------------------------------------------------------------------
   // Software reset
   // ------------------------------------------------------------------
   AST_SWRST_DEFAULTS: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      swrst && !wr_mcfg |=> mcfg_r == (gcm_pkg::RST_MCFG1
      | gcm_pkg::MASK_SWRST) && !bank_r)
      else $error("fields not at default during software reset");

   AST_SWRST_OUTPUTS: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      seq_swrst_write |=> seq_reset_outputs)
      else $error("outputs not at default on software reset");

   AST_SWRST_BANK: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      seq_swrst_write ##1 1'b1 |=> !mem_bank_sel && !bank_r)
      else $error("bank select kept during software reset");

   AST_SWRST_RELEASE: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      seq_swrst_clear |=> !swrst ##1 !dev_reset)
      else $error("software reset not released by write");

   AST_SWRST_HOLD: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      swrst && !(wr_mcfg && !reg_wdata[gcm_pkg::BIT_SWRST])
      |=> swrst)
      else $error("software reset dropped without clearing write");

   AST_DEVRST_MIRROR: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg |=> dev_reset == swrst)
      else $error("device reset output differs from reset bit");

   AST_RSV_ZERO: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (mcfg_r & ~gcm_pkg::MASK_MCFG1) == 8'h00)
      else $error("reserved configuration bit set");

   // ------------------------------------------------------------------
   // Master clock, ring oscillator and pin mode
   // ------------------------------------------------------------------
   AST_IC1_WINS: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg && mcfg_nxt[gcm_pkg::BIT_SEL_IC1]
      |=> master_clock_src == gcm_pkg::GCM_SRC_IC1)
      else $error("input clock one not selected");

   AST_XA_SEL: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg && !mcfg_nxt[gcm_pkg::BIT_SEL_IC1]
      |=> master_clock_src == (mcfg_r[gcm_pkg::BIT_SEL_XA] ?
      gcm_pkg::GCM_SRC_XA : gcm_pkg::GCM_SRC_RING))
      else $error("wrong master clock choice");

   AST_SRC_LEGAL: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      master_clock_src inside {gcm_pkg::GCM_SRC_RING,
      gcm_pkg::GCM_SRC_XA, gcm_pkg::GCM_SRC_IC1})
      else $error("master clock source code illegal");

   AST_DBL_FOLLOWS: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg |=> clock_doubler_enable == mcfg_r[gcm_pkg::BIT_DBL])
      else $error("clock doubler enable mismatch");

   AST_RING_PD: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg |=> ring_osc_en == !mcfg_r[gcm_pkg::BIT_ROSC_DIS])
      else $error("ring oscillator enable mismatch");

   AST_XAB_DECODE: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg ##1 !wr_mcfg |-> !(xtal_drv_en && xa_se_en)
      && (xtal_drv_en == (mcfg_r[gcm_pkg::BIT_XAB_HI:gcm_pkg::BIT_XAB_LO]
      == gcm_pkg::GCM_XAB_XTAL)))
      else $error("pin mode decode wrong");

   AST_SE_DECODE: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg |=> xa_se_en == (mcfg_r[gcm_pkg::BIT_XAB_HI:gcm_pkg::BIT_XAB_LO]
      == gcm_pkg::GCM_XAB_SE))
      else $error("single-ended pin mode decode wrong");

   AST_XAB_IDLE: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      wr_mcfg && (xab_nxt == gcm_pkg::GCM_XAB_UNUSED
      || xab_nxt == gcm_pkg::GCM_XAB_OFF)
      |=> !xtal_drv_en && !xa_se_en)
      else $error("pin driver enabled in off or unused mode");

   AST_RESET_RING: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(arst_n) |-> ring_osc_en
      && master_clock_src == gcm_pkg::GCM_SRC_RING)
      else $error("ring oscillator not default after reset");

endmodule // gcm_global_config

// >>> pkg/gcm_pkg.sv
package gcm_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [11:0] ADDR_BANK_SEL = 12'h000;
   localparam logic [11:0] ADDR_MCFG1 = 12'h009;
   localparam logic [11:0] ADDR_BANK_LO = 12'h001;
   localparam logic [7:0] RST_BANK_SEL = 8'h00;
   localparam logic [7:0] RST_MCFG1 = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // ------------------------------------------------------------------
   // Field positions of the bank select register and master_configuration_one
   // ------------------------------------------------------------------
   localparam int BIT_BANK = 0;
   localparam int BIT_SWRST = 7;
   localparam int BIT_SEL_IC1 = 5;
   localparam int BIT_SEL_XA = 4;
   localparam int BIT_ROSC_DIS = 3;
   localparam int BIT_DBL = 2;
   localparam int BIT_XAB_HI = 1;
   localparam int BIT_XAB_LO = 0;
   // Bits kept on a write while in software reset
   localparam logic [7:0] MASK_SWRST = 8'h80;
   // Implemented bits (bit 6 reserved)
   localparam logic [7:0] MASK_MCFG1 = 8'hBF;
   // ------------------------------------------------------------------
   // Enumerations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      GCM_SRC_RING = 2'h0,
      GCM_SRC_XA = 2'h1,
      GCM_SRC_IC1 = 2'h3
   } gcm_src_t;
   typedef enum logic [1:0] {
      GCM_XAB_OFF = 2'h0,
      GCM_XAB_XTAL = 2'h1,
      GCM_XAB_SE = 2'h2,
      GCM_XAB_UNUSED = 2'h3
   } gcm_xab_t;
endpackage

// >>> test/gcm_global_config_tb.sv
`timescale 1ns/1ps
module gcm_global_config_tb;
   logic sys_clk, arst_n, reg_wr, reg_rd;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic mem_bank_sel, mem_window_hit, dev_reset, ring_osc_en;
   logic clock_doubler_enable, xtal_drv_en, xa_se_en;
   logic [1:0] master_clock_src;
   logic [7:0] tv [11] = '{8'h00, 8'h20, 8'h30, 8'h10, 8'h18, 8'h28,
                           8'h04, 8'h01, 8'h02, 8'h03, 8'h7F};
   int num_errors = 0;
   int n_compared = 0;
   gcm_global_config #(.HAS_INT_MEM(1'b1)) dut (.sys_clk(sys_clk),
      .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_bank_sel(mem_bank_sel), .mem_window_hit(mem_window_hit),
      .dev_reset(dev_reset), .master_clock_src(master_clock_src),
      .ring_osc_en(ring_osc_en),
      .clock_doubler_enable(clock_doubler_enable),
      .xtal_drv_en(xtal_drv_en), .xa_se_en(xa_se_en));
   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   function automatic logic [7:0] outs();
      return {ring_osc_en, dev_reset, master_clock_src,
              clock_doubler_enable, xtal_drv_en, xa_se_en, mem_bank_sel};
   endfunction
   // Expected outputs worked out from a configuration byte
   function automatic logic [7:0] exp_outs(input logic [7:0] d);
      logic [1:0] s;
      s = d[5] ? 2'h3 : {1'b0, d[4]};
      return {~d[3], 1'b0, s, d[2], d[1:0] == 2'h1, d[1:0] == 2'h2, 1'b0};
   endfunction
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      #10000;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      chk(outs(), 8'h80);
      rd(12'h009, 8'h00);
      $display("reset test done");
      foreach (tv[i]) begin
         wr(12'h009, tv[i]);
         chk(outs(), exp_outs(tv[i]));
         rd(12'h009, tv[i] & 8'hBF);
      end
      rd(12'h005, 8'h00);
      $display("clock select test done");
      wr(12'h000, 8'h01);
      chk({7'h00, mem_bank_sel}, 8'h01);
      rd(12'h000, 8'h00);
      wr(12'h009, 8'h10);
      chk({6'h00, master_clock_src}, 8'h03);
      rd(12'h010, 8'h00);
      chk({7'h00, mem_window_hit}, 8'h01);
      wr(12'h000, 8'h00);
      chk({7'h00, mem_bank_sel}, 8'h00);
      $display("bank test done");
      wr(12'h009, 8'h3F);
      wr(12'h009, 8'h04);
      wr(12'h009, 8'h84);
      chk(outs(), 8'hC0);
      rd(12'h009, 8'h80);
      wr(12'h009, 8'h98);
      rd(12'h009, 8'h80);
      wr(12'h009, 8'h00);
      chk(outs(), 8'h80);
      $display("software reset test done");
      complete_run();
   end
endmodule // gcm_global_config_tb
